// ### logic/fsqg_host.sv
// Host controller that drives a parallel flash through its secure sector and query commands.
// How it works
// - Exit secure sector before touching main array.
// - Write needs chip select, strobe low, OE high.
// - Query command 98h at word 55h.
// - Reset command leaves query back to array.
// - Query from identification returns there on reset.
`timescale 1ns/1ns
`default_nettype none
`include "fsqg_defs.svh"
module fsqg_host (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                req_valid,
    input  wire fsqg_pkg::fsqg_req_t req,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output fsqg_pkg::fsqg_rsp_t      rsp,
    output fsqg_pkg::fsqg_mode_t     mode,
    input  wire logic                ready_busy_n,
    input  wire logic                supply_lockout,
    input  wire logic [15:0]         dq_i,
    output fsqg_pkg::fsqg_pins_t     pins
);
    import fsqg_pkg::*;

    typedef struct packed {
        fsqg_state_t st;
        fsqg_req_t   req;
        logic [2:0]  idx;
        fsqg_mode_t  mode;
        logic        from_ident;
        logic        ready;
        logic        rsp_valid;
        fsqg_rsp_t   rsp;
        logic [2:0]  ryb_s;
        logic [2:0]  low_s;
        logic        busy;
        logic        low;
    } fsqg_host_state_t;

    localparam fsqg_host_state_t RESET_STATE = '{st: ST_IDLE, req: '0, idx: '0, mode: MODE_ARRAY,
                                                 from_ident: 1'b0, ready: 1'b0, rsp_valid: 1'b0,
                                                 rsp: '0, ryb_s: 3'h7, low_s: 3'h0, busy: 1'b0,
                                                 low: 1'b0};

    // Bus cycle number idx of the command sequence for op.
    function automatic fsqg_step_t seq_step(fsqg_op_t op, logic [2:0] idx, fsqg_req_t r);
        fsqg_step_t s;
        s = '{addr: `FSQG_UNLOCK1_ADDR, data: `FSQG_CMD_UNLOCK1, rd: 1'b0, last: 1'b0};
        if (idx == 3'h1 || idx == 3'h4) begin
            s.addr = `FSQG_UNLOCK2_ADDR;
            s.data = `FSQG_CMD_UNLOCK2;
        end
        unique case (op)
            OP_READ: begin
                s = '{addr: r.addr, data: '0, rd: 1'b1, last: 1'b1};
            end
            OP_PROGRAM: begin
                if (idx == 3'h2) begin
                    s.data = `FSQG_CMD_PROGRAM;
                end else if (idx == 3'h3) begin
                    s = '{addr: r.addr, data: r.data, rd: 1'b0, last: 1'b1};
                end
            end
            OP_ERASE: begin
                if (idx == 3'h2) begin
                    s.data = `FSQG_CMD_ERASE;
                end else if (idx == 3'h5) begin
                    s = '{addr: r.addr, data: `FSQG_CMD_SECTOR, rd: 1'b0, last: 1'b1};
                end
            end
            OP_QUERY: begin
                s = '{addr: `FSQG_QUERY_ADDR, data: `FSQG_CMD_QUERY, rd: 1'b0, last: 1'b1};
            end
            OP_RESET: begin
                s = '{addr: `FSQG_ANY_ADDR, data: `FSQG_CMD_RESET, rd: 1'b0, last: 1'b1};
            end
            OP_SEC_ENTER: begin
                if (idx == 3'h2) begin
                    s.data = `FSQG_CMD_SEC_ENTER;
                    s.last = 1'b1;
                end
            end
            OP_SEC_EXIT: begin
                if (idx == 3'h2) begin
                    s.data = `FSQG_CMD_AUTOSEL;
                end else if (idx == 3'h3) begin
                    s = '{addr: `FSQG_ANY_ADDR, data: `FSQG_CMD_SEC_EXIT, rd: 1'b0, last: 1'b1};
                end
            end
            OP_IDENT: begin
                if (idx == 3'h2) begin
                    s.data = `FSQG_CMD_AUTOSEL;
                    s.last = 1'b1;
                end
            end
        endcase
        return s;
    endfunction

    // Decides whether a request is turned away before any bus cycle.
    function automatic logic refused(fsqg_req_t r, fsqg_mode_t m, logic busy, logic low);
        logic bad;
        bad = 1'b0;
        if (low && r.op != OP_READ) begin
            bad = 1'b1;
        end
        if (r.op == OP_QUERY && (busy || !(m == MODE_ARRAY || m == MODE_IDENT))) begin
            bad = 1'b1;
        end
        if (m == MODE_SECURE && (r.op == OP_READ || r.op == OP_PROGRAM || r.op == OP_ERASE)
            && r.addr < `FSQG_SECURE_BASE) begin
            bad = 1'b1;
        end
        if ((m == MODE_QUERY || m == MODE_IDENT) && (r.op == OP_PROGRAM || r.op == OP_ERASE)) begin
            bad = 1'b1;
        end
        return bad;
    endfunction

    fsqg_host_state_t q;
    fsqg_host_state_t d;
    fsqg_step_t       step;
    logic             accept;
    logic             bus_done;
    logic [15:0]      bus_rdata;

    assign step   = seq_step(q.req.op, q.idx, q.req);
    assign accept = req_valid && q.ready;

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.ryb_s = {q.ryb_s[1:0], ready_busy_n};
        d.low_s = {q.low_s[1:0], supply_lockout};
        if (q.ryb_s[1] == q.ryb_s[2]) begin
            d.busy = !q.ryb_s[2];
        end
        if (q.low_s[1] == q.low_s[2]) begin
            d.low = q.low_s[2];
        end
        if (q.low) begin
            d.mode       = MODE_ARRAY;
            d.from_ident = 1'b0;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (accept) begin
                    if (refused(req, q.mode, q.busy, q.low)) begin
                        d.rsp_valid = 1'b1;
                        d.rsp       = '{rdata: '0, err: 1'b1};
                    end else begin
                        d.req = req;
                        d.idx = 3'h0;
                        d.st  = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                d.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (bus_done) begin
                    if (q.low && !step.rd) begin
                        d.rsp_valid = 1'b1;
                        d.rsp       = '{rdata: '0, err: 1'b1};
                        d.st        = ST_IDLE;
                    end else if (step.last) begin
                        d.rsp_valid = 1'b1;
                        d.rsp       = '{rdata: bus_rdata, err: 1'b0};
                        d.st        = ST_IDLE;
                        unique case (q.req.op)
                            OP_QUERY: begin
                                d.from_ident = (q.mode == MODE_IDENT);
                                d.mode       = MODE_QUERY;
                            end
                            OP_RESET: begin
                                d.mode       = (q.mode == MODE_QUERY && q.from_ident) ? MODE_IDENT : MODE_ARRAY;
                                d.from_ident = 1'b0;
                            end
                            OP_SEC_ENTER: d.mode = MODE_SECURE;
                            OP_SEC_EXIT:  d.mode = MODE_ARRAY;
                            OP_IDENT:     d.mode = MODE_IDENT;
                            default: ;
                        endcase
                    end else begin
                        d.idx = q.idx + 3'h1;
                        d.st  = ST_ISSUE;
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        d.ready = (d.st == ST_IDLE) && !accept;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    fsqg_bus_cycle u_bus (
        .clk     (clk),
        .rstn    (rstn),
        .start   (q.st == ST_ISSUE),
        .is_read (step.rd),
        .addr    (step.addr),
        .data    (step.data),
        .dq_i    (dq_i),
        .pins    (pins),
        .rdata   (bus_rdata),
        .done    (bus_done)
    );

    assign req_ready = q.ready;
    assign rsp_valid = q.rsp_valid;
    assign rsp       = q.rsp;
    assign mode      = q.mode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_query_busy_refuse: assert property ((accept && req.op == OP_QUERY && q.busy) |=> (rsp_valid && rsp.err))
        else $error("Query accepted while the flash was busy.");
    a_lockout_refuse: assert property ((accept && req.op != OP_READ && q.low) |=> (rsp_valid && rsp.err))
        else $error("Write command accepted during supply lockout.");
    a_lockout_mode: assert property (q.low |=> (mode == MODE_ARRAY))
        else $error("Mode not back to array read during lockout.");
    a_reset_to_ident: assert property ((bus_done && step.last && q.req.op == OP_RESET && q.st == ST_WAIT && !q.low
                                        && q.mode == MODE_QUERY && q.from_ident) |=> (mode == MODE_IDENT))
        else $error("Reset from query did not return to identification.");
    a_secure_exit_first: assert property ((accept && q.mode == MODE_SECURE && req.op == OP_READ
                                           && req.addr < `FSQG_SECURE_BASE) |=> rsp.err)
        else $error("Main array read issued while secure sector mapped.");
    a_query_command: assert property ((q.st == ST_ISSUE && q.req.op == OP_QUERY)
                                      |-> (step.addr == `FSQG_QUERY_ADDR && step.data == `FSQG_CMD_QUERY))
        else $error("Query command not 98h at word 55h.");
    a_program_unlock: assert property ((q.st == ST_ISSUE && q.req.op == OP_PROGRAM && q.idx == 3'h0)
                                       |-> (step.data == `FSQG_CMD_UNLOCK1 && !step.last))
        else $error("Program did not open with an unlock cycle.");
    a_program_full_seq: assert property ((q.st == ST_ISSUE && q.req.op == OP_PROGRAM && step.last)
                                         |-> (q.idx == 3'h3))
        else $error("Program sequence shorter than the full four cycles.");

    c_query_entry: cover property (bus_done && q.st == ST_WAIT && q.req.op == OP_QUERY && step.last);
    c_secure_entry: cover property (mode == MODE_SECURE);
    c_program_done: cover property (bus_done && q.st == ST_WAIT && q.req.op == OP_PROGRAM && step.last);
    c_ident_query_back: cover property (mode == MODE_QUERY && q.from_ident ##[1:200] mode == MODE_IDENT);
endmodule
`default_nettype wire

// ### logic/fsqg_defs.svh
// Constants for the flash secure sector and query host controller.
`ifndef FSQG_DEFS_SVH
`define FSQG_DEFS_SVH
`define FSQG_CLK_NS        4
`define FSQG_GLITCH_NS     5
`define FSQG_SETUP_NS      8
`define FSQG_STROBE_NS     40
`define FSQG_HOLD_NS       8
`define FSQG_CYC(ns)       (((ns) + `FSQG_CLK_NS - 1) / `FSQG_CLK_NS)
`define FSQG_READ_EXTRA    3
`define FSQG_UNLOCK1_ADDR  21'h000555
`define FSQG_UNLOCK2_ADDR  21'h0002aa
`define FSQG_QUERY_ADDR    21'h000055
`define FSQG_ANY_ADDR      21'h000000
`define FSQG_SECURE_BASE   21'h1f8000
`define FSQG_CMD_UNLOCK1   16'h00aa
`define FSQG_CMD_UNLOCK2   16'h0055
`define FSQG_CMD_PROGRAM   16'h00a0
`define FSQG_CMD_ERASE     16'h0080
`define FSQG_CMD_SECTOR    16'h0030
`define FSQG_CMD_QUERY     16'h0098
`define FSQG_CMD_RESET     16'h00f0
`define FSQG_CMD_SEC_ENTER 16'h0088
`define FSQG_CMD_AUTOSEL   16'h0090
`define FSQG_CMD_SEC_EXIT  16'h0000
`endif

// ### logic/fsqg_pkg.sv
// Types for the flash secure sector and query host controller.
package fsqg_pkg;
    typedef enum logic [2:0] {
        OP_READ      = 3'b000,
        OP_PROGRAM   = 3'b001,
        OP_ERASE     = 3'b010,
        OP_QUERY     = 3'b011,
        OP_RESET     = 3'b100,
        OP_SEC_ENTER = 3'b101,
        OP_SEC_EXIT  = 3'b110,
        OP_IDENT     = 3'b111
    } fsqg_op_t;
    typedef enum logic [1:0] {
        MODE_ARRAY  = 2'b00,
        MODE_QUERY  = 2'b01,
        MODE_IDENT  = 2'b10,
        MODE_SECURE = 2'b11
    } fsqg_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } fsqg_state_t;
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_SETUP  = 2'b01,
        BUS_STROBE = 2'b10,
        BUS_HOLD   = 2'b11
    } fsqg_bus_st_t;
    typedef struct packed {
        fsqg_op_t    op;
        logic [20:0] addr;
        logic [15:0] data;
    } fsqg_req_t;
    typedef struct packed {
        logic [15:0] rdata;
        logic        err;
    } fsqg_rsp_t;
    typedef struct packed {
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [20:0] addr;
        logic [15:0] dq_o;
        logic        dq_oe;
    } fsqg_pins_t;
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] data;
        logic        rd;
        logic        last;
    } fsqg_step_t;
endpackage

// ### logic/fsqg_bus_cycle.sv
// One asynchronous flash bus cycle, read or write, with strobe timing.
`timescale 1ns/1ns
`default_nettype none
`include "fsqg_defs.svh"
module fsqg_bus_cycle #(
    parameter int unsigned SETUP_CYC  = `FSQG_CYC(`FSQG_SETUP_NS),
    parameter int unsigned STROBE_CYC = `FSQG_CYC(`FSQG_STROBE_NS),
    parameter int unsigned HOLD_CYC   = `FSQG_CYC(`FSQG_HOLD_NS)
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                start,
    input  wire logic                is_read,
    input  wire logic [20:0]         addr,
    input  wire logic [15:0]         data,
    input  wire logic [15:0]         dq_i,
    output fsqg_pkg::fsqg_pins_t     pins,
    output logic [15:0]              rdata,
    output logic                     done
);
    import fsqg_pkg::*;

    typedef struct packed {
        fsqg_bus_st_t      st;
        logic [7:0]        cnt;
        logic              rd;
        logic [2:0][15:0]  sync;
        fsqg_pins_t        pins;
        logic [15:0]       rdata;
        logic              done;
    } fsqg_bus_state_t;

    localparam fsqg_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    localparam fsqg_bus_state_t RESET_STATE = '{st: BUS_IDLE, cnt: '0, rd: 1'b0, sync: '0,
                                                pins: PINS_IDLE, rdata: '0, done: 1'b0};

    fsqg_bus_state_t q;
    fsqg_bus_state_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.sync = {q.sync[1:0], dq_i};
        unique case (q.st)
            BUS_IDLE: begin
                if (start) begin
                    d.pins.addr  = addr;
                    d.pins.ce_n  = 1'b0;
                    d.pins.dq_o  = data;
                    d.pins.dq_oe = !is_read;
                    d.rd         = is_read;
                    d.cnt        = 8'(SETUP_CYC - 1);
                    d.st         = BUS_SETUP;
                end
            end
            BUS_SETUP: begin
                if (q.cnt == 8'h00) begin
                    if (q.rd) begin
                        d.pins.oe_n = 1'b0;
                        d.cnt       = 8'(STROBE_CYC + `FSQG_READ_EXTRA - 1);
                    end else begin
                        d.pins.we_n = 1'b0;
                        d.cnt       = 8'(STROBE_CYC - 1);
                    end
                    d.st = BUS_STROBE;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
            BUS_STROBE: begin
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else if (!q.rd || q.sync[1] == q.sync[2]) begin
                    d.pins.we_n = 1'b1;
                    d.pins.oe_n = 1'b1;
                    if (q.rd) begin
                        d.rdata = q.sync[2];
                    end
                    d.cnt = 8'(HOLD_CYC - 1);
                    d.st  = BUS_HOLD;
                end
            end
            BUS_HOLD: begin
                if (q.cnt == 8'h00) begin
                    d.pins.ce_n  = 1'b1;
                    d.pins.dq_oe = 1'b0;
                    d.done       = 1'b1;
                    d.st         = BUS_IDLE;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign pins  = q.pins;
    assign rdata = q.rdata;
    assign done  = q.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_write_gating: assert property (!q.pins.we_n |-> (!q.pins.ce_n && q.pins.oe_n))
        else $error("Write strobe low without chip select low and output enable high.");
    a_strobe_width: assert property ($fell(q.pins.we_n) |=> !q.pins.we_n [*2])
        else $error("Write strobe pulse too short to pass the glitch filter.");
    a_reset_idle: assert property (disable iff (1'b0) !rstn |=> (q.pins.we_n && q.pins.ce_n && q.pins.oe_n))
        else $error("Strobes not idle after reset.");
endmodule
`default_nettype wire

// ### verification/fsqg_flash_model.sv
// Behavioural parallel flash that answers the host controller.
`timescale 1ns/1ns
`default_nettype none
module fsqg_flash_model #(
    parameter bit FACTORY_LOCKED = 1'b0
) (
    input  wire fsqg_pkg::fsqg_pins_t pins,
    input  wire logic                 lockout,
    output logic [15:0]               dq_i,
    output logic                      ready_busy_n
);
    import fsqg_pkg::*;
    logic [15:0] mm [int];
    logic [15:0] sm [int];
    fsqg_mode_t  m = MODE_ARRAY;
    int          st = 0;
    bit          ers = 0;
    bit          qid = 0;
    bit          busy = 0;
    logic [15:0] last = 16'h0000;
    realtime     t_fall = 0;
    event        go;
    function automatic logic [15:0] qtab(input int a);
        case (a)
            'h10: return 16'h0051;
            'h11: return 16'h0052;
            'h12: return 16'h0059;
            'h13: return 16'h0002;
            'h15: return 16'h0040;
            'h1b: return 16'h0027;
            'h1c: return 16'h0036;
            'h1f: return 16'h0004;
            'h21: return 16'h000a;
            'h23: return 16'h0005;
            'h25: return 16'h0004;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] rdv(input int a);
        if (m == MODE_QUERY) return qtab(a);
        if (m == MODE_SECURE) return sm.exists(a) ? sm[a] : a[15:0] ^ 16'h5a5a;
        return mm.exists(a) ? mm[a] : ~a[15:0];
    endfunction
    task automatic wr(input int a, input logic [15:0] d);
        if (lockout || busy) return;
        if (st == 3) begin
            if (m == MODE_SECURE) begin
                if (!FACTORY_LOCKED) sm[a] = rdv(a) & d;
            end else begin
                mm[a] = rdv(a) & d;
            end
            ->go;
            st = 0;
        end else if (d == 16'h00f0) begin
            m = qid ? MODE_IDENT : MODE_ARRAY;
            qid = 0;
            st = 0;
        end else if (d == 16'h0098 && a == 'h55 && m inside {MODE_ARRAY, MODE_IDENT}) begin
            qid = (m == MODE_IDENT);
            m = MODE_QUERY;
        end else if (d == 16'h00aa && a == 'h555) begin
            st = 1;
        end else if (st == 1 && d == 16'h0055 && a == 'h2aa) begin
            st = 2;
        end else if (st == 2) begin
            st = (d == 16'h00a0) ? 3 : 0;
            if (d == 16'h0088) m = MODE_SECURE;
            if (d == 16'h0090) m = MODE_IDENT;
            if (d == 16'h0030 && ers) mm.delete();
            if (d == 16'h0030 && ers) ->go;
            ers = (d == 16'h0080);
        end else begin
            if (m == MODE_IDENT && d == 16'h0000) m = MODE_ARRAY;
            st = 0;
        end
    endtask
    always @(negedge pins.we_n) t_fall = $realtime;
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.oe_n && $realtime - t_fall >= 5) wr(int'(pins.addr), pins.dq_o);
    end
    always @(posedge lockout) begin
        m = MODE_ARRAY;
        st = 0;
    end
    always @(go) begin
        busy = 1;
        #600;
        busy = 0;
    end
    assign ready_busy_n = ~busy;
    always @(pins or m) begin
        if (!pins.ce_n && !pins.oe_n) begin
            dq_i = rdv(int'(pins.addr));
            last = dq_i;
        end else begin
            dq_i = ~last;
        end
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the flash secure sector and query host controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fsqg_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        req_valid = 1'b0;
    fsqg_req_t   req = '0;
    logic        req_ready;
    logic        rsp_valid;
    fsqg_rsp_t   rsp;
    fsqg_mode_t  mode;
    logic        ready_busy_n;
    logic        supply_lockout = 1'b0;
    logic [15:0] dq_i;
    fsqg_pins_t  pins;
    int          fails = 0;
    int          n_checks = 0;
    int          seed = 99;
    int          wlow = 0;
    int          k;
    fsqg_mode_t  m = MODE_ARRAY;
    bit          qid = 0;
    bit          busy = 0;
    bit          lock = 0;
    logic [15:0] mm [int];
    logic [15:0] sm [int];
    logic [20:0] a;
    logic [15:0] d;
    localparam logic [15:0] QTAB [23] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000, 16'h0000, 16'h0004,
        16'h0000, 16'h000a, 16'h0000, 16'h0005, 16'h0000, 16'h0004, 16'h0000};
    always #2 clk = ~clk;
    fsqg_host i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .mode(mode), .ready_busy_n(ready_busy_n),
        .supply_lockout(supply_lockout), .dq_i(dq_i), .pins(pins));
    fsqg_flash_model i_flash (.pins(pins), .lockout(supply_lockout), .dq_i(dq_i), .ready_busy_n(ready_busy_n));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(inout int c, input int lim);
        c++;
        if (c > lim) begin
            fails++;
            $display("MISMATCH %0t wait limit", $time);
            end_of_test();
        end
        @(negedge clk);
    endtask
    task automatic wait_rdy();
        k = 0;
        while (ready_busy_n !== 1'b1) tick(k, 500);
        repeat (5) @(negedge clk);
        busy = 0;
    endtask
    function automatic logic [15:0] rd_mem(input logic [20:0] x);
        if (m == MODE_QUERY) return (x >= 21'h10 && x <= 21'h26) ? QTAB[5'(x - 21'h10)] : 16'h0000;
        if (m == MODE_SECURE) return sm.exists(x) ? sm[x] : x[15:0] ^ 16'h5a5a;
        return mm.exists(x) ? mm[x] : ~x[15:0];
    endfunction
    task automatic run(input fsqg_op_t op, input logic [20:0] x, input logic [15:0] v);
        logic        e_err;
        logic [15:0] e_rd;
        int          c;
        e_err = (op != OP_READ && lock) || (op == OP_QUERY && (busy || !(m inside {MODE_ARRAY, MODE_IDENT})))
            || (op inside {OP_READ, OP_PROGRAM, OP_ERASE} && x < 21'h1f8000 && m == MODE_SECURE)
            || (op inside {OP_PROGRAM, OP_ERASE} && m inside {MODE_QUERY, MODE_IDENT});
        e_rd = rd_mem(x);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{op: op, addr: x, data: v};
        c = 0;
        while (req_ready !== 1'b1) tick(c, 50);
        @(negedge clk);
        req_valid = 1'b0;
        c = 0;
        while (rsp_valid !== 1'b1) tick(c, 400);
        chk(rsp.err, e_err);
        if (op == OP_READ && !e_err) chk(rsp.rdata, e_rd);
        if (!e_err) begin
            case (op)
                OP_QUERY: begin
                    qid = (m == MODE_IDENT);
                    m = MODE_QUERY;
                end
                OP_RESET: begin
                    m = qid ? MODE_IDENT : MODE_ARRAY;
                    qid = 0;
                end
                OP_SEC_ENTER: m = MODE_SECURE;
                OP_SEC_EXIT: m = MODE_ARRAY;
                OP_IDENT: m = MODE_IDENT;
                OP_PROGRAM: begin
                    if (m == MODE_SECURE) sm[x] = e_rd & v;
                    else mm[x] = e_rd & v;
                end
                OP_ERASE: mm.delete();
                default: ;
            endcase
        end
        @(negedge clk);
        chk(mode, m);
    endtask
    always @(negedge clk) begin
        if (pins.we_n === 1'b0) wlow <= wlow + 1;
        if (pins.oe_n === 1'b0) chk({pins.we_n, pins.dq_oe}, 2'b10);
        if (pins.we_n === 1'b1 && wlow > 0) begin
            chk(wlow, 10);
            chk({pins.ce_n, pins.oe_n, pins.dq_oe}, 3'b011);
            wlow <= 0;
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        chk({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe, req_ready}, 5'b11100);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        chk(req_ready, 1'b1);
        run(OP_QUERY, 21'h000055, 16'h0000);
        for (int i = 'h0f; i <= 'h27; i++) run(OP_READ, 21'(i), 16'h0000);
        run(OP_PROGRAM, 21'h000100, 16'h1234);
        run(OP_QUERY, 21'h000055, 16'h0000);
        run(OP_RESET, 21'h000000, 16'h0000);
        repeat (4) begin
            a = 21'($random(seed) & 'hfffff);
            d = 16'($random(seed));
            run(OP_PROGRAM, a, d);
            repeat (6) @(negedge clk);
            busy = 1;
            run(OP_QUERY, 21'h000055, 16'h0000);
            wait_rdy();
            run(OP_READ, a, 16'h0000);
        end
        run(OP_ERASE, 21'h000000, 16'h0000);
        wait_rdy();
        run(OP_READ, a, 16'h0000);
        run(OP_IDENT, 21'h000000, 16'h0000);
        run(OP_QUERY, 21'h000055, 16'h0000);
        run(OP_READ, 21'h000011, 16'h0000);
        run(OP_RESET, 21'h000000, 16'h0000);
        run(OP_PROGRAM, a, d);
        run(OP_RESET, 21'h000000, 16'h0000);
        run(OP_SEC_ENTER, 21'h000000, 16'h0000);
        run(OP_READ, 21'h001000, 16'h0000);
        for (int i = 0; i < 8; i++) run(OP_READ, 21'h1f8000 + 21'(i), 16'h0000);
        run(OP_PROGRAM, 21'h1f8003, 16'h00ff);
        wait_rdy();
        run(OP_READ, 21'h1f8003, 16'h0000);
        run(OP_SEC_EXIT, 21'h000000, 16'h0000);
        run(OP_READ, 21'h1f8003, 16'h0000);
        supply_lockout = 1'b1;
        lock = 1;
        repeat (5) @(negedge clk);
        run(OP_PROGRAM, a, d);
        run(OP_QUERY, 21'h000055, 16'h0000);
        run(OP_READ, a, 16'h0000);
        supply_lockout = 1'b0;
        lock = 0;
        repeat (5) @(negedge clk);
        repeat (4) run(OP_READ, 21'($random(seed) & 'hfffff), 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
